// *** design/psm_command_engine.sv ***
/*
  Command and state engine of a PS/2 pointing device, with its byte link
  on the open-drain clock and data wires and an Avalon-MM register slave.
  Assumes one 200 MHz clock; the link wires are asynchronous and pulled up
  outside; the host keeps to PS/2 host timing.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psm_map.svh"
module psm_command_engine #(
  parameter int unsigned HALF_BIT_CYC = `PSM_HALF_BIT_US * `PSM_CLK_MHZ,
  parameter int unsigned POR_CYC      = `PSM_POR_MS * 1000 * `PSM_CLK_MHZ,
  parameter int unsigned SWRST_CYC    = `PSM_SWRST_MS * 1000 * `PSM_CLK_MHZ,
  parameter logic [7:0]  ID_STD       = 8'h5A, // Arbitrary value
  parameter logic [7:0]  ID_EXT       = 8'h5B  // Arbitrary value
) (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        ps2_clk_in,
  output logic             ps2_clk_out,
  output logic             ps2_clk_oe_n_out,
  input  wire logic        ps2_dat_in,
  output logic             ps2_dat_out,
  output logic             ps2_dat_oe_n_out,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out
);
  import psm_pkg::*;

  psm_state_type s, n;

  function automatic logic tx_bit(input logic [3:0] b, input logic [7:0] d);
    tx_bit = 1'b1;
    if (b == 4'h0) tx_bit = 1'b0;
    else if (b <= 4'h8) tx_bit = d[3'(b - 4'h1)];
    else if (b == 4'h9) tx_bit = ~^d;
  endfunction

  function automatic logic [9:0] add_sat(input logic [8:0] a, input logic [7:0] d);
    logic signed [10:0] sum;
    sum = $signed({{2{a[8]}}, a}) + $signed({{3{d[7]}}, d});
    if (sum > $signed(11'h0FF)) add_sat = {1'b1, 9'h0FF};
    else if (sum < $signed(11'h700)) add_sat = {1'b1, 9'h100};
    else add_sat = {1'b0, sum[8:0]};
  endfunction

  function automatic logic rate_ok(input logic [7:0] r);
    rate_ok = (r == 8'h0A) || (r == 8'h14) || (r == 8'h28) || (r == 8'h3C) ||
              (r == 8'h50) || (r == 8'h64) || (r == 8'hC8);
  endfunction

  function automatic logic [7:0] seq_val(input logic [2:0] i);
    seq_val = (i == 3'h0) ? `PSM_SEQ_0 : (i == 3'h1) ? `PSM_SEQ_1 :
              (i == 3'h2) ? `PSM_SEQ_2 : `PSM_SEQ_3;
  endfunction

  always_comb begin
    logic [3:0][7:0] rb;
    logic [2:0]      rl;
    logic            keep;
    logic            clr_acc;
    logic            invalid;
    logic [7:0]      pk1, st1;
    logic [9:0]      rx_sum, ry_sum;
    rb = '0;
    rl = 3'h0;
    keep = 1'b0;
    clr_acc = 1'b0;
    invalid = 1'b0;
    rx_sum = 10'h000;
    ry_sum = 10'h000;
    n = s;
    n.clk_s1 = ps2_clk_in;
    n.clk_s2 = s.clk_s1;
    n.dat_s1 = ps2_dat_in;
    n.dat_s2 = s.dat_s1;
    n.rx_done = 1'b0;
    n.avs_ack = 1'b0;
    pk1 = {s.ovf_y, s.ovf_x, s.acc_y[8], s.acc_x[8], 1'b1, s.btn[1], s.btn[2], s.btn[0]};
    st1 = {1'b0, s.remote, s.enable, s.scaling, 1'b0, s.btn[0], s.btn[1], s.btn[2]};

    // Bit-level link
    unique case (s.link)
      LK_IDLE: begin
        n.clk_drv = 1'b0;
        n.dat_drv = 1'b0;
        n.half_cnt = 16'h0000;
        n.phase = 1'b0;
        if (s.clk_s2 && !s.dat_s2) begin
          n.link = LK_RX;
          n.bit_idx = 4'h1;
          n.frm_err = 1'b0;
          n.stop_bad = 1'b0;
        end else if (s.clk_s2 && s.dat_s2 && (s.out_idx < s.out_len)) begin
          n.link = LK_TX;
          n.sh = s.out_buf[s.out_idx[1:0]];
          n.bit_idx = 4'h0;
          n.dat_drv = 1'b1;
        end
      end
      LK_TX, LK_RX: begin
        if (s.half_cnt != 16'(HALF_BIT_CYC - 1)) begin
          n.half_cnt = s.half_cnt + 16'h0001;
        end else begin
          n.half_cnt = 16'h0000;
          if (!s.phase) begin
            if (!s.clk_s2) begin
              // Host inhibit: a byte past its tenth clock counts as sent
              n.link = LK_IDLE;
              n.dat_drv = 1'b0;
              if (s.link == LK_TX && s.bit_idx >= 4'hA) n.out_idx = s.out_idx + 3'h1;
            end else begin
              n.phase = 1'b1;
              n.clk_drv = 1'b1;
            end
          end else begin
            n.phase = 1'b0;
            n.clk_drv = 1'b0;
            if (s.link == LK_TX) begin
              if (s.bit_idx == 4'hA) begin
                n.link = LK_IDLE;
                n.dat_drv = 1'b0;
                n.out_idx = s.out_idx + 3'h1;
              end else begin
                n.bit_idx = s.bit_idx + 4'h1;
                n.dat_drv = !tx_bit(s.bit_idx + 4'h1, s.sh);
              end
            end else if (s.bit_idx == 4'hA) begin
              // Host bit set while clock low; sampled just before the rise
              n.stop_bad = !s.dat_s2;
              if (!s.dat_s2) n.frm_err = 1'b1;
              else begin
                n.bit_idx = 4'hB;
                n.dat_drv = 1'b1;
              end
            end else if (s.bit_idx == 4'hB) begin
              n.link = LK_IDLE;
              n.dat_drv = 1'b0;
              n.rx_done = 1'b1;
              n.rx_byte = s.sh;
              n.rx_err = s.frm_err | s.stop_bad | ~(^{s.sh, s.rx_par});
            end else begin
              if (s.bit_idx <= 4'h8) n.sh = {s.dat_s2, s.sh[7:1]};
              else n.rx_par = s.dat_s2;
              n.bit_idx = s.bit_idx + 4'h1;
            end
          end
        end
      end
      default: n.link = LK_IDLE;
    endcase

    // Self-test delay
    if (s.delay_cnt != 32'h0) n.delay_cnt = s.delay_cnt - 32'h1;

    // Command decode
    if (s.rx_done) begin
      n.out_idx = s.out_len;
      if (s.rx_byte != `PSM_CMD_RESEND) clr_acc = 1'b1;
      if (s.por_pend && s.rx_byte != `PSM_CMD_RESET) n.rst_pend = 1'b0;
      if (s.rx_err) begin
        invalid = 1'b1;
      end else if (s.wrap && s.rx_byte != `PSM_CMD_RESET) begin
        if (s.rx_byte == `PSM_CMD_UNWRAP) begin
          n.wrap = 1'b0;
          n.enable = 1'b0;
          rb[0] = `PSM_RSP_ACK;
          rl = 3'h1;
          keep = 1'b1;
        end else begin
          rb[0] = s.rx_byte;
          rl = 3'h1;
          keep = 1'b1;
        end
      end else if (s.arg_cmd != 8'h00) begin
        n.arg_cmd = 8'h00;
        if (s.arg_cmd == `PSM_CMD_RATE && rate_ok(s.rx_byte)) begin
          n.rate = s.rx_byte;
          if (s.rx_byte == seq_val(s.seq_idx)) begin
            n.seq_idx = s.seq_idx + 3'h1;
            if (s.seq_idx == 3'h3) begin
              n.extended = 1'b1;
              n.seq_idx = 3'h0;
            end
          end else begin
            n.seq_idx = (s.rx_byte == `PSM_SEQ_0) ? 3'h1 : 3'h0;
          end
        end else if (s.arg_cmd == `PSM_CMD_RES && s.rx_byte <= `PSM_MAX_RES) begin
          n.res = s.rx_byte[1:0];
        end else begin
          invalid = 1'b1;
        end
        if (!invalid) begin
          rb[0] = `PSM_RSP_ACK;
          rl = 3'h1;
          keep = 1'b1;
        end
      end else begin
        rb[0] = `PSM_RSP_ACK;
        rl = 3'h1;
        keep = 1'b1;
        if (s.rx_byte != `PSM_CMD_RATE) n.seq_idx = 3'h0;
        unique case (s.rx_byte)
          `PSM_CMD_RESET: begin
            n.rst_pend = 1'b1;
            n.wrap = 1'b0;
            n.extended = 1'b0;
            if (!s.por_pend) n.delay_cnt = 32'(SWRST_CYC);
          end
          `PSM_CMD_RESEND: begin
            rb = {8'h00, s.last_buf};
            rl = s.last_len;
            keep = 1'b0;
          end
          `PSM_CMD_DEFAULT: ;
          `PSM_CMD_DISABLE: n.enable = 1'b0;
          `PSM_CMD_ENABLE: n.enable = 1'b1;
          `PSM_CMD_RATE, `PSM_CMD_RES: n.arg_cmd = s.rx_byte;
          `PSM_CMD_TYPE: begin
            rb[1] = s.extended ? ID_EXT : ID_STD;
            rl = 3'h2;
          end
          `PSM_CMD_REMOTE: n.remote = 1'b1;
          `PSM_CMD_STREAM: n.remote = 1'b0;
          `PSM_CMD_WRAP: n.wrap = 1'b1;
          `PSM_CMD_UNWRAP: ;
          `PSM_CMD_READ: begin
            rb[3:1] = {s.acc_y[7:0], s.acc_x[7:0], pk1};
            rl = 3'h4;
            n.btn_sent = s.btn;
          end
          `PSM_CMD_STATUS: begin
            rb[3:1] = {s.rate, 6'h00, s.res, st1};
            rl = 3'h4;
          end
          `PSM_CMD_SCALE2: n.scaling = 1'b1;
          `PSM_CMD_SCALE1: n.scaling = 1'b0;
          default: begin
            invalid = 1'b1;
            rl = 3'h0;
            keep = 1'b0;
          end
        endcase
        if (s.rx_byte == `PSM_CMD_RESET || s.rx_byte == `PSM_CMD_DEFAULT) begin
          n.rate = `PSM_DFLT_RATE;
          n.res = `PSM_DFLT_RES;
          n.scaling = 1'b0;
          n.remote = 1'b0;
          n.enable = 1'b0;
          n.arg_cmd = 8'h00;
        end
      end
      if (invalid) begin
        rb[0] = s.last_inv ? `PSM_RSP_ERROR : `PSM_RSP_RESEND;
        rl = 3'h1;
        n.last_inv = 1'b1;
        n.seq_idx = 3'h0;
        n.arg_cmd = 8'h00;
      end else begin
        n.last_inv = 1'b0;
      end
    end else if (s.rst_pend && s.delay_cnt == 32'h0 && s.out_idx == s.out_len && s.link == LK_IDLE) begin
      n.rst_pend = 1'b0;
      n.por_pend = 1'b0;
      if (!(s.por_pend && s.clk_s2 && !s.dat_s2)) begin
        rb[1:0] = {s.extended ? ID_EXT : ID_STD, s.st_fail ? `PSM_RSP_ERROR : `PSM_RSP_PASS};
        rl = 3'h2;
        keep = 1'b1;
      end
    end else if (!s.rst_pend && !s.wrap && !s.remote && s.enable && s.link == LK_IDLE &&
                 s.out_idx == s.out_len && s.arg_cmd == 8'h00 &&
                 (s.acc_x != 9'h0 || s.acc_y != 9'h0 || s.ovf_x || s.ovf_y || s.btn != s.btn_sent)) begin
      rb[2:0] = {s.acc_y[7:0], s.acc_x[7:0], pk1};
      rl = 3'h3;
      keep = 1'b1;
      clr_acc = 1'b1;
      n.btn_sent = s.btn;
    end
    if (s.por_pend && s.delay_cnt == 32'h0 && !s.rst_pend) n.por_pend = 1'b0;

    if (rl != 3'h0) begin
      n.out_buf = rb;
      n.out_len = rl;
      n.out_idx = 3'h0;
      if (keep) begin
        n.last_buf = (rb[0] == `PSM_RSP_ACK && rl != 3'h1) ? rb[3:1] : rb[2:0];
        n.last_len = (rb[0] == `PSM_RSP_ACK && rl != 3'h1) ? rl - 3'h1 : rl;
      end
    end
    if (clr_acc) begin
      n.acc_x = 9'h000;
      n.acc_y = 9'h000;
      n.ovf_x = 1'b0;
      n.ovf_y = 1'b0;
    end

    // Avalon slave, one wait cycle
    if ((avs_read_in || avs_write_in) && !s.avs_ack) begin
      n.avs_ack = 1'b1;
      unique case (avs_address_in)
        `PSM_REG_BUTTONS: n.avs_rd = {28'h0, s.st_fail, s.btn};
        `PSM_REG_STATUS: n.avs_rd = {8'h00, s.rate, 6'h00, s.res,
                                     2'h0, s.rst_pend, s.extended, s.wrap, s.scaling, s.enable, s.remote};
        `PSM_REG_ACCUM: n.avs_rd = {6'h00, s.ovf_y, s.acc_y, 6'h00, s.ovf_x, s.acc_x};
        default: n.avs_rd = 32'h0;
      endcase
    end
    if (avs_write_in && s.avs_ack) begin
      if (avs_address_in == `PSM_REG_MOTION) begin
        rx_sum = add_sat(n.acc_x, avs_writedata_in[7:0]);
        ry_sum = add_sat(n.acc_y, avs_writedata_in[15:8]);
        n.acc_x = rx_sum[8:0];
        n.acc_y = ry_sum[8:0];
        n.ovf_x = n.ovf_x | rx_sum[9];
        n.ovf_y = n.ovf_y | ry_sum[9];
      end else if (avs_address_in == `PSM_REG_BUTTONS) begin
        n.btn = avs_writedata_in[2:0];
        n.st_fail = avs_writedata_in[3];
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s <= '0;
      s.rate <= `PSM_DFLT_RATE;
      s.res <= `PSM_DFLT_RES;
      s.last_buf <= {8'h00, ID_STD, `PSM_RSP_PASS};
      s.last_len <= 3'h2;
      s.delay_cnt <= 32'(POR_CYC);
      s.rst_pend <= 1'b1;
      s.por_pend <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign ps2_clk_out = 1'b0;
  assign ps2_dat_out = 1'b0;
  assign ps2_clk_oe_n_out = !s.clk_drv;
  assign ps2_dat_oe_n_out = !s.dat_drv;
  assign avs_readdata_out = s.avs_rd;
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !s.avs_ack;

  // Checks
  logic cmd_in;
  assign cmd_in = s.rx_done && !s.rx_err && !s.wrap && (s.arg_cmd == 8'h00);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  property p_status_ack;
    cmd_in && s.rx_byte == `PSM_CMD_STATUS |=> s.out_len == 3'h4 && s.out_buf[0] == `PSM_RSP_ACK;
  endproperty
  a_status_ack: assert property (p_status_ack) else $error("status reply not led by ack");

  property p_disable;
    cmd_in && s.rx_byte == `PSM_CMD_DISABLE |=> !s.enable && s.out_buf[0] == `PSM_RSP_ACK;
  endproperty
  a_disable: assert property (p_disable) else $error("disable did not clear enable");

  property p_acc_clear;
    s.rx_done && s.rx_byte != `PSM_CMD_RESEND && !(avs_write_in && s.avs_ack) |=> s.acc_x == 9'h0 && s.acc_y == 9'h0;
  endproperty
  a_acc_clear: assert property (p_acc_clear) else $error("accumulators not cleared");

  property p_second_invalid;
    s.rx_done && s.rx_err && s.last_inv |=> s.out_buf[0] == `PSM_RSP_ERROR && s.out_len == 3'h1;
  endproperty
  a_second_invalid: assert property (p_second_invalid) else $error("second invalid not error");

  property p_wrap_echo;
    s.rx_done && !s.rx_err && s.wrap && s.rx_byte != `PSM_CMD_RESET && s.rx_byte != `PSM_CMD_UNWRAP
      |=> s.out_buf[0] == $past(s.rx_byte) && s.out_len == 3'h1;
  endproperty
  a_wrap_echo: assert property (p_wrap_echo) else $error("wrap echo wrong");

  property p_ext_entry;
    $rose(s.extended) |-> $past(s.arg_cmd) == `PSM_CMD_RATE && $past(s.rx_byte) == `PSM_SEQ_3;
  endproperty
  a_ext_entry: assert property (p_ext_entry) else $error("extended mode entered wrongly");

  property p_parity;
    s.link == LK_TX && s.phase && s.bit_idx == 4'h9 |-> s.dat_drv == (^s.sh);
  endproperty
  a_parity: assert property (p_parity) else $error("parity bit not odd");

  property p_defaults;
    cmd_in && s.rx_byte == `PSM_CMD_DEFAULT
      |=> s.rate == `PSM_DFLT_RATE && s.res == `PSM_DFLT_RES && !s.scaling && !s.remote && !s.enable;
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults not restored");

  property p_read_data;
    cmd_in && s.rx_byte == `PSM_CMD_READ |=> s.out_len == 3'h4 && s.out_buf[1][3] ##1 s.out_idx == 3'h0;
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data reply wrong");

endmodule // psm_command_engine
`default_nettype wire

// *** design/psm_map.svh ***
/*
  Constants of the pointing-device command engine: command and reply codes,
  register offsets, power-up defaults and timing figures.
  Assumes inclusion by bare name from the engine and the bench.
*/
`ifndef PSM_MAP_SVH
`define PSM_MAP_SVH

// System clock, link timing and self-test delays
`define PSM_CLK_MHZ       200
`define PSM_HALF_BIT_US   40
`define PSM_POR_MS        300
`define PSM_SWRST_MS      300

// Host command codes
`define PSM_CMD_RESET     8'hFF
`define PSM_CMD_RESEND    8'hFE
`define PSM_CMD_DEFAULT   8'hF6
`define PSM_CMD_DISABLE   8'hF5
`define PSM_CMD_ENABLE    8'hF4
`define PSM_CMD_RATE      8'hF3
`define PSM_CMD_TYPE      8'hF2
`define PSM_CMD_REMOTE    8'hF0
`define PSM_CMD_WRAP      8'hEE
`define PSM_CMD_UNWRAP    8'hEC
`define PSM_CMD_READ      8'hEB
`define PSM_CMD_STREAM    8'hEA
`define PSM_CMD_STATUS    8'hE9
`define PSM_CMD_RES       8'hE8
`define PSM_CMD_SCALE2    8'hE7
`define PSM_CMD_SCALE1    8'hE6

// Device reply codes
`define PSM_RSP_ACK       8'hFA
`define PSM_RSP_PASS      8'hAA
`define PSM_RSP_ERROR     8'hFC
`define PSM_RSP_RESEND    8'hFE

// Extended-mode rate sequence
`define PSM_SEQ_0         8'hC8
`define PSM_SEQ_1         8'h64
`define PSM_SEQ_2         8'h50
`define PSM_SEQ_3         8'h3C

// Power-up defaults and highest resolution argument
`define PSM_DFLT_RATE     8'h64
`define PSM_DFLT_RES      2'h2
`define PSM_MAX_RES       8'h03

// Avalon register byte offsets
`define PSM_REG_MOTION    4'h0
`define PSM_REG_BUTTONS   4'h4
`define PSM_REG_STATUS    4'h8
`define PSM_REG_ACCUM     4'hC

`endif

// *** design/psm_pkg.sv ***
/*
  Types of the pointing-device command engine: link state and the packed
  state record of the engine.
  Assumes psm_map.svh on the include path.
*/
`default_nettype none
package psm_pkg;
  typedef enum logic [1:0] {
    LK_IDLE = 2'b00,
    LK_TX   = 2'b01,
    LK_RX   = 2'b10
  } psm_link_type;

  typedef struct packed {
    logic                 clk_s1, clk_s2, dat_s1, dat_s2;
    psm_link_type         link;
    logic [15:0]          half_cnt;
    logic                 phase;
    logic [3:0]           bit_idx;
    logic [7:0]           sh;
    logic                 rx_par, stop_bad, frm_err;
    logic                 clk_drv, dat_drv;
    logic                 rx_done, rx_err;
    logic [7:0]           rx_byte;
    logic [3:0][7:0]      out_buf;
    logic [2:0]           out_len, out_idx;
    logic [2:0][7:0]      last_buf;
    logic [2:0]           last_len;
    logic                 remote, enable, scaling, wrap, extended;
    logic [7:0]           rate;
    logic [1:0]           res;
    logic [7:0]           arg_cmd;
    logic                 last_inv;
    logic [2:0]           seq_idx;
    logic [8:0]           acc_x, acc_y;
    logic                 ovf_x, ovf_y;
    logic [2:0]           btn, btn_sent;
    logic                 st_fail;
    logic [31:0]          delay_cnt;
    logic                 rst_pend, por_pend;
    logic [31:0]          avs_rd;
    logic                 avs_ack;
  } psm_state_type;
endpackage
`default_nettype wire

// *** tb/psm_command_engine_tb.sv ***
/*
  Bench of the pointing-device engine: host model on the link, register
  tasks on the slave port, a table of command rows, then awkward cases.
  Assumes short self-test and bit timing parameters.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psm_map.svh"
module psm_command_engine_tb;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic [3:0]  avs_address_in = 4'h0;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic        clk_oe_n, dat_oe_n, ps2_clk, ps2_dat;
  logic        clk_o, dat_o;
  int          failures = 0;
  int          tests_run = 0;
  logic [31:0] rd;
  logic [7:0]  rb;
  logic        ok;
  // Row: command byte, reply count, up to four reply bytes
  logic [43:0] rows [$] = '{
    44'hE94FA000264,
    44'hF31FA000000, 44'h281FA000000, 44'hE81FA000000, 44'h031FA000000,
    44'hE71FA000000, 44'hF01FA000000, 44'hF41FA000000, 44'hE94FA700328,
    44'hE61FA000000, 44'hEA1FA000000, 44'hF51FA000000, 44'hE94FA000328,
    44'hF61FA000000, 44'hE94FA000264, 44'hF22FA5A0000,
    44'hEB4FA080000, 44'hFE308000000,
    44'h011FE000000, 44'h021FC000000, 44'hF22FA5A0000, 44'h031FE000000,
    44'hF31FA000000, 44'hC81FA000000, 44'hF31FA000000, 44'h641FA000000,
    44'hF31FA000000, 44'h501FA000000, 44'hF31FA000000, 44'h3C1FA000000,
    44'hF22FA5B0000,
    44'hF41FA000000, 44'hEE1FA000000, 44'h55155000000, 44'hF41F4000000,
    44'hEC1FA000000, 44'hE94FA00023C, 44'hF41FA000000,
    44'hEC1FA000000, 44'hE94FA20023C,
    44'hFF3FAAA5A00, 44'hFE2AA5A0000, 44'hF22FA5A0000};

  always #2.5 clk_in = ~clk_in;

  psm_command_engine #(.HALF_BIT_CYC(8), .POR_CYC(200), .SWRST_CYC(100)) dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .ps2_clk_in(ps2_clk), .ps2_clk_out(clk_o),
    .ps2_clk_oe_n_out(clk_oe_n), .ps2_dat_in(ps2_dat), .ps2_dat_out(dat_o), .ps2_dat_oe_n_out(dat_oe_n),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out));

  psm_host_model host (.clk_in(clk_in), .dev_clk_oe_n_in(clk_oe_n), .dev_dat_oe_n_in(dat_oe_n),
    .ps2_clk_out(ps2_clk), .ps2_dat_out(ps2_dat));

  task automatic summarize();
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Hold the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= wd;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  task automatic take(input int n, input logic [31:0] rsp);
    for (int k = 0; k < n; k++) begin
      host.recv_byte(rb, ok);
      chk({31'h0, ok}, 32'h1);
      chk({24'h0, rb}, {24'h0, rsp[31-8*k -: 8]});
    end
  endtask

  task automatic cmd(input logic [7:0] b, input int n, input logic [31:0] rsp);
    host.send_byte(b);
    take(n, rsp);
  endtask

  initial begin
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    take(2, 32'hAA5A0000);
    foreach (rows[i]) begin
      cmd(rows[i][43:36], int'(rows[i][35:32]), rows[i][31:0]);
    end
    bus(1'b1, `PSM_REG_MOTION, 32'h0000FE03);
    bus(1'b0, `PSM_REG_ACCUM, 32'h0);
    chk(rd, 32'h01FE0003);
    cmd(8'hFE, 1, 32'h5A000000);
    bus(1'b0, `PSM_REG_ACCUM, 32'h0);
    chk(rd, 32'h01FE0003);
    cmd(8'hEB, 4, 32'hFA2803FE);
    bus(1'b0, `PSM_REG_ACCUM, 32'h0);
    chk(rd, 32'h0);
    cmd(8'hF4, 1, 32'hFA000000);
    bus(1'b1, `PSM_REG_MOTION, 32'h00000210);
    take(3, 32'h08100200);
    bus(1'b1, `PSM_REG_BUTTONS, 32'h00000005);
    take(3, 32'h0B000000);
    cmd(8'hF5, 1, 32'hFA000000);
    cmd(8'hE9, 4, 32'hFA050264);
    host.send_byte(8'hE9);
    take(1, 32'hFA000000);
    cmd(8'hF2, 2, 32'hFA5A0000);
    host.send_frame(10'h301);
    take(1, 32'hFE000000);
    host.send_frame(10'h301);
    take(1, 32'hFC000000);
    bus(1'b1, `PSM_REG_BUTTONS, 32'h00000008);
    cmd(8'hFF, 3, 32'hFAFC5A00);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk({30'h0, clk_oe_n, dat_oe_n}, 32'h3);
    nrst_in <= 1'b1;
    cmd(8'hF2, 2, 32'hFA5A0000);
    repeat (300) @(posedge clk_in);
    bus(1'b0, `PSM_REG_STATUS, 32'h0);
    chk(rd & 32'h00FF033F, 32'h00640200);
    chk({30'h0, clk_o, dat_o}, 32'h0);
    summarize();
  end

  initial begin
    repeat (80000) @(posedge clk_in);
    failures++;
    summarize();
  end
endmodule // psm_command_engine_tb
`default_nettype wire

// *** tb/psm_host_model.sv ***
/*
  Host port model: pulled-up link wire levels, byte send and receive tasks.
  Assumes one caller at a time and a device that clocks the link.
*/
`timescale 1ns/1ps
`default_nettype none
module psm_host_model (
  input  wire logic clk_in,
  input  wire logic dev_clk_oe_n_in,
  input  wire logic dev_dat_oe_n_in,
  output logic      ps2_clk_out,
  output logic      ps2_dat_out
);
  logic host_clk_reg = 1'b1;
  logic host_dat_reg = 1'b1;
  // Wire low when either side drives
  assign ps2_clk_out = dev_clk_oe_n_in & host_clk_reg;
  assign ps2_dat_out = dev_dat_oe_n_in & host_dat_reg;

  // Inhibit, request to send, then a bit after each falling clock
  task automatic send_frame(input logic [9:0] frm);
    @(posedge clk_in) host_clk_reg <= 1'b0;
    repeat (20) @(posedge clk_in);
    host_dat_reg <= 1'b0;
    @(posedge clk_in) host_clk_reg <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(negedge ps2_clk_out);
      @(posedge clk_in) host_dat_reg <= frm[i];
    end
    @(negedge ps2_clk_out);
    @(posedge ps2_clk_out);
  endtask

  task automatic send_byte(input logic [7:0] b);
    send_frame({1'b1, ~^b, b});
  endtask

  // Sample data at each falling clock
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    logic [10:0] sh;
    for (int i = 0; i < 11; i++) begin
      @(negedge ps2_clk_out);
      sh[i] = ps2_dat_out;
    end
    b = sh[8:1];
    ok = !sh[0] && sh[10] && ^sh[9:1];
  endtask
endmodule // psm_host_model
`default_nettype wire
